// *** logic/dbtc_map.svh ***
// Register indices, field positions and reset values of the dual-byte timer
`ifndef DBTC_MAP_SVH
`define DBTC_MAP_SVH

// Register indices; byte address is four times the index
`define DBTC_IDX_CONTROL      16'hfe10
`define DBTC_IDX_PRESCALE     16'hfe11
`define DBTC_IDX_COUNT_LOW    16'hfe12
`define DBTC_IDX_COUNT_HIGH   16'hfe13
`define DBTC_IDX_MATCH_LOW    16'hfe14
`define DBTC_IDX_MATCH_HIGH   16'hfe15
`define DBTC_IDX_SNAP_A_LOW   16'hfe16
`define DBTC_IDX_SNAP_A_HIGH  16'hfe17
`define DBTC_IDX_SNAP_B_LOW   16'hfe1e
`define DBTC_IDX_SNAP_B_HIGH  16'hfe1f

// Control register field positions
`define DBTC_BIT_HIGH_RUN     7
`define DBTC_BIT_LOW_RUN      6
`define DBTC_BIT_LENGTH       5
`define DBTC_BIT_LOW_CLKSEL   4
`define DBTC_BIT_HIGH_FLAG    3
`define DBTC_BIT_HIGH_IE      2
`define DBTC_BIT_LOW_FLAG     1
`define DBTC_BIT_LOW_IE       0

// Reset values
`define DBTC_RST_CONTROL      8'h00
`define DBTC_RST_PRESCALE     8'h00
`define DBTC_RST_COUNT        8'h00
`define DBTC_RST_MATCH        8'h00

// Count value at which the low byte carries into the high byte
`define DBTC_BYTE_MAX         8'hff

`endif

// *** logic/dbtc_pkg.sv ***
// Types shared by the dual-byte timer modules
package dbtc_pkg;

    // Detection pulses from the pin event logic
    typedef struct packed {
        logic countEvent;
        logic lowCapture;
        logic highCapture;
        logic secondLowCapture;
        logic secondHighCapture;
    } dbtc_evt_t;

    // Control register layout
    typedef struct packed {
        logic highRun;
        logic lowRun;
        logic lengthSelect;
        logic lowClockSelect;
        logic highMatchFlag;
        logic highIrqEnable;
        logic lowMatchFlag;
        logic lowIrqEnable;
    } dbtc_ctrl_t;

    // Bus transfer types
    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'b00,
        HTRANS_BUSY   = 2'b01,
        HTRANS_NONSEQ = 2'b10,
        HTRANS_SEQ    = 2'b11
    } dbtc_htrans_t;

    // Decoded register selector
    typedef enum logic [3:0] {
        REG_NONE        = 4'b0000,
        REG_CONTROL     = 4'b0001,
        REG_PRESCALE    = 4'b0010,
        REG_COUNT_LOW   = 4'b0011,
        REG_COUNT_HIGH  = 4'b0100,
        REG_MATCH_LOW   = 4'b0101,
        REG_MATCH_HIGH  = 4'b0110,
        REG_SNAP_A_LOW  = 4'b0111,
        REG_SNAP_A_HIGH = 4'b1000,
        REG_SNAP_B_LOW  = 4'b1001,
        REG_SNAP_B_HIGH = 4'b1010
    } dbtc_reg_t;

endpackage

// *** logic/dbtc_prescaler.sv ***
// Programmable 8-bit prescaler producing the timer tick
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_map.svh"
module dbtc_prescaler
    import dbtc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic [7:0] matchValue,
    input  wire logic       matchWrite,
    input  wire logic       holdMode,
    // Tick out
    output logic            tick
);
    logic [7:0] count;

    assign tick = !holdMode && (count == matchValue);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `DBTC_RST_COUNT;
        end else if (matchWrite || tick) begin
            count <= `DBTC_RST_COUNT;
        end else if (!holdMode) begin
            count <= count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** logic/dbtc_byte_counter.sv ***
// One byte counter with its match buffer
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_map.svh"
module dbtc_byte_counter
    import dbtc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic       advance,
    input  wire logic       matchHit,
    input  wire logic [7:0] matchData,
    // State
    output logic [7:0]      count,
    output logic [7:0]      matchBuffer
);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `DBTC_RST_COUNT;
        end else if (!run || matchHit) begin
            count <= `DBTC_RST_COUNT;
        end else if (advance) begin
            count <= count + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            matchBuffer <= `DBTC_RST_MATCH;
        end else if (!run || matchHit) begin
            matchBuffer <= matchData;
        end
    end
endmodule
`default_nettype wire

// *** logic/dbtc_timer.sv ***
// Dual-byte timer/counter with prescaler, match buffers, capture and AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_map.svh"
module dbtc_timer
    import dbtc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Chip state and detection pulses
    input  wire logic        holdMode,
    input  wire dbtc_evt_t   events,
    // Interrupt requests
    output logic             lowIrq,
    output logic             highIrq
);

    // Bus state
    logic       accessValid;
    dbtc_reg_t  addrReg;
    logic       writePending;
    dbtc_reg_t  writeReg;
    logic [7:0] writeData;
    logic [7:0] next_rdata;

    // Registers
    dbtc_ctrl_t control;
    logic [7:0] prescaleMatch;
    logic [7:0] matchDataLow;
    logic [7:0] matchDataHigh;
    logic [7:0] snapALow;
    logic [7:0] snapAHigh;
    logic [7:0] snapBLow;
    logic [7:0] snapBHigh;

    // Counting datapath; index 0 is the low byte, 1 the high byte
    logic       tick;
    logic       prescaleWrite;
    logic       run        [2];
    logic       advance    [2];
    logic       matchHit   [2];
    logic [7:0] matchData  [2];
    logic [7:0] count      [2];
    logic [7:0] buffer     [2];
    logic       lowEqual;
    logic       highEqual;
    logic       wideHit;
    logic       lowCarry;
    logic       lowCapEvt;
    logic       secondLowCapEvt;

    // Word address decode, shared by read and write paths
    function automatic dbtc_reg_t decodeReg(input logic [31:0] addr);
        logic [15:0] idx;
        idx = addr[17:2];
        decodeReg = REG_NONE;
        if (addr[31:18] == 14'h0000 && addr[1:0] == 2'b00) begin
            case (idx)
                `DBTC_IDX_CONTROL:     decodeReg = REG_CONTROL;
                `DBTC_IDX_PRESCALE:    decodeReg = REG_PRESCALE;
                `DBTC_IDX_COUNT_LOW:   decodeReg = REG_COUNT_LOW;
                `DBTC_IDX_COUNT_HIGH:  decodeReg = REG_COUNT_HIGH;
                `DBTC_IDX_MATCH_LOW:   decodeReg = REG_MATCH_LOW;
                `DBTC_IDX_MATCH_HIGH:  decodeReg = REG_MATCH_HIGH;
                `DBTC_IDX_SNAP_A_LOW:  decodeReg = REG_SNAP_A_LOW;
                `DBTC_IDX_SNAP_A_HIGH: decodeReg = REG_SNAP_A_HIGH;
                `DBTC_IDX_SNAP_B_LOW:  decodeReg = REG_SNAP_B_LOW;
                `DBTC_IDX_SNAP_B_HIGH: decodeReg = REG_SNAP_B_HIGH;
                default:               decodeReg = REG_NONE;
            endcase
        end
    endfunction

    // Address phase; BUSY and IDLE carry no transfer
    assign accessValid = hsel && hready &&
                         (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign addrReg     = decodeReg(haddr);

    // Zero wait states, always OKAY
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Write address held for the data phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            writePending <= 1'b0;
            writeReg     <= REG_NONE;
        end else begin
            writePending <= accessValid && hwrite && (addrReg != REG_NONE);
            writeReg     <= addrReg;
        end
    end

    assign writeData     = hwdata[7:0];
    assign prescaleWrite = writePending && (writeReg == REG_PRESCALE);

    // Read data sampled at the address phase; unmapped reads give zero
    always_comb begin
        case (addrReg)
            REG_CONTROL:     next_rdata = control;
            REG_PRESCALE:    next_rdata = prescaleMatch;
            REG_COUNT_LOW:   next_rdata = count[0];
            REG_COUNT_HIGH:  next_rdata = count[1];
            REG_MATCH_LOW:   next_rdata = matchDataLow;
            REG_MATCH_HIGH:  next_rdata = matchDataHigh;
            REG_SNAP_A_LOW:  next_rdata = snapALow;
            REG_SNAP_A_HIGH: next_rdata = snapAHigh;
            REG_SNAP_B_LOW:  next_rdata = snapBLow;
            REG_SNAP_B_HIGH: next_rdata = snapBHigh;
            default:         next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (accessValid && !hwrite) begin
            hrdata <= {24'h00_0000, next_rdata};
        end
    end

    // Plain writable data registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescaleMatch <= `DBTC_RST_PRESCALE;
            matchDataLow  <= `DBTC_RST_MATCH;
            matchDataHigh <= `DBTC_RST_MATCH;
        end else if (writePending) begin
            case (writeReg)
                REG_PRESCALE:   prescaleMatch <= writeData;
                REG_MATCH_LOW:  matchDataLow  <= writeData;
                REG_MATCH_HIGH: matchDataHigh <= writeData;
                default:        prescaleMatch <= prescaleMatch;
            endcase
        end
    end

    // Control register; hardware set of a flag wins over a software clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= `DBTC_RST_CONTROL;
        end else begin
            if (writePending && writeReg == REG_CONTROL) begin
                control <= writeData;
            end
            if (matchHit[0]) begin
                control.lowMatchFlag <= 1'b1;
            end
            if (matchHit[1]) begin
                control.highMatchFlag <= 1'b1;
            end
        end
    end

    dbtc_prescaler u_prescaler (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .matchValue (prescaleMatch),
        .matchWrite (prescaleWrite),
        .holdMode   (holdMode),
        .tick       (tick)
    );

    assign run[0]       = control.lowRun;
    assign run[1]       = control.highRun;
    assign matchData[0] = matchDataLow;
    assign matchData[1] = matchDataHigh;

    assign advance[0] = control.lowRun &&
                        (control.lowClockSelect ? events.countEvent : tick);

    // Carry only when the low byte wraps without a full match
    assign lowCarry   = advance[0] && (count[0] == `DBTC_BYTE_MAX) && !wideHit;

    assign advance[1] = control.highRun &&
                        (control.lengthSelect ? lowCarry : tick);

    assign lowEqual  = (count[0] == buffer[0]);
    assign highEqual = (count[1] == buffer[1]);

    assign wideHit = control.lengthSelect && advance[0] && control.highRun &&
                     lowEqual && highEqual;

    // match on the step from the match value
    assign matchHit[0] = control.lengthSelect ? wideHit : (advance[0] && lowEqual);
    assign matchHit[1] = control.lengthSelect ? wideHit : (advance[1] && highEqual);

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_byte
            dbtc_byte_counter u_byte (
                .core_clk    (core_clk),
                .rst_n       (rst_n),
                .run         (run[i]),
                .advance     (advance[i]),
                .matchHit    (matchHit[i]),
                .matchData   (matchData[i]),
                .count       (count[i]),
                .matchBuffer (buffer[i])
            );
        end
    endgenerate

    assign lowCapEvt       = control.lengthSelect ? events.highCapture
                                                  : events.lowCapture;
    assign secondLowCapEvt = control.lengthSelect ? events.secondHighCapture
                                                  : events.secondLowCapture;

    // Snapshots carry no reset; contents undefined until first capture
    // hold until next capture
    always_ff @(posedge core_clk) begin
        if (lowCapEvt) begin
            snapALow <= count[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (events.highCapture) begin
            snapAHigh <= count[1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (secondLowCapEvt) begin
            snapBLow <= count[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (events.secondHighCapture) begin
            snapBHigh <= count[1];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowIrq  <= 1'b0;
            highIrq <= 1'b0;
        end else begin
            lowIrq  <= control.lowMatchFlag && control.lowIrqEnable;
            highIrq <= control.highMatchFlag && control.highIrqEnable;
        end
    end

endmodule
`default_nettype wire

// *** tb/dbtc_timer_asserts.sv ***
// Port-level assertions for the dual-byte timer
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_map.svh"
module dbtc_timer_asserts
    import dbtc_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Requests
    input wire logic        lowIrq,
    input wire logic        highIrq
);
    logic       rdTaken;
    logic       mapped;
    logic       ctrlWrData;
    logic [1:0] ieShadow;

    assign rdTaken = hsel && hready && htrans[1] && !hwrite;
    assign mapped = haddr[1:0] == 2'b00 && haddr[31:18] == 14'h0 && (haddr[17:2] inside
        {[`DBTC_IDX_CONTROL:`DBTC_IDX_SNAP_A_HIGH], `DBTC_IDX_SNAP_B_LOW, `DBTC_IDX_SNAP_B_HIGH});

    // Data phase of a control write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlWrData <= 1'b0;
        end else begin
            ctrlWrData <= hsel && hready && htrans[1] && hwrite
                && haddr == {14'h0, `DBTC_IDX_CONTROL, 2'b00};
        end
    end

    // Mirror of both enable bits, lands with the register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ieShadow <= 2'b00;
        end else if (ctrlWrData) begin
            ieShadow <= {hwdata[`DBTC_BIT_HIGH_IE], hwdata[`DBTC_BIT_LOW_IE]};
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_READY: assert property (hreadyout == 1'b1)
        else $error("hreadyout dropped");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    AST_RDATA_STABLE: assert property (!$past(rdTaken) |-> $stable(hrdata))
        else $error("hrdata changed without a read");
    AST_UNMAPPED_ZERO: assert property (rdTaken && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    // Request needs its enable
    AST_LOW_IRQ_EN: assert property (lowIrq |-> $past(ieShadow[0]))
        else $error("low request without enable");
    AST_HIGH_IRQ_EN: assert property (highIrq |-> $past(ieShadow[1]))
        else $error("high request without enable");
    // Flags drop only by software
    AST_LOW_FLAG_HOLD: assert property ($fell(lowIrq) |-> $past(ctrlWrData, 2))
        else $error("low request fell without control write");
    AST_HIGH_FLAG_HOLD: assert property ($fell(highIrq) |-> $past(ctrlWrData, 2))
        else $error("high request fell without control write");

    cover property ($rose(lowIrq) && $rose(highIrq));
    cover property ($fell(highIrq));
    cover property (rdTaken && !mapped);
endmodule

bind dbtc_timer dbtc_timer_asserts u_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .lowIrq(lowIrq), .highIrq(highIrq)
);
`default_nettype wire

// *** tb/dbtc_evt_model.sv ***
// Pin event detector model producing detection pulses
`timescale 1ns/10ps
`default_nettype none
module dbtc_evt_model
    import dbtc_pkg::*;
(
    // Clock
    input  wire logic     core_clk,
    // Detection pulses
    output var dbtc_evt_t events
);
    initial begin
        events = '0;
    end

    task automatic pulse(input int unsigned sel, input int unsigned gap);
        dbtc_evt_t one;
        one = '0;
        one[sel] = 1'b1;
        @(posedge core_clk);
        events <= one;
        @(posedge core_clk);
        events <= '0;
        repeat (gap) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the dual-byte timer
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_map.svh"
module tb_top
    import dbtc_pkg::*;
;
    localparam int EV_CNT = 4, EV_LC = 3, EV_HC = 2, EV_LC2 = 1, EV_HC2 = 0;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        holdMode = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = HTRANS_IDLE;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, lowIrq, highIrq;
    dbtc_evt_t   events;
    logic [7:0]  rd;
    int          failures = 0;
    int          tests_run = 0;
    int          cyc = 0;

    dbtc_timer uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .holdMode(holdMode), .events(events), .lowIrq(lowIrq), .highIrq(highIrq));
    dbtc_evt_model u_evt (.core_clk(core_clk), .events(events));

    always #2 core_clk = ~core_clk;

    // Hang guard, well above the longest run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Single word transfer, waits on hready in both phases
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= HTRANS_IDLE;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
        hsel <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [15:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(name, 32'(rd), 32'(exp));
    endtask

    task automatic waitIrq(input logic hi, output int t);
        while ((hi ? highIrq : lowIrq) === 1'b1) @(posedge core_clk);
        while ((hi ? highIrq : lowIrq) !== 1'b1) @(posedge core_clk);
        t = cyc;
    endtask

    function automatic int period(input int m, input int p);
        return (m + 1) * (p + 1);
    endfunction

    initial begin
        int t0, t1, t2, want;
        logic [7:0] p, m, m2, ctl;
        logic hi;
        void'($urandom(44658));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values, read-only and unmapped places
        for (int k = 0; k < 6; k++) begin
            rdchk("reset value", `DBTC_IDX_CONTROL + 16'(k), 8'h00);
        end
        bus(`DBTC_IDX_COUNT_LOW, 1'b1, 8'h5a);
        rdchk("count low ignores write", `DBTC_IDX_COUNT_LOW, 8'h00);
        bus(16'hfe18, 1'b1, 8'h33);
        rdchk("unmapped", 16'hfe18, 8'h00);
        $display("test registers done");
        // Prescaled periods, buffer reload, hold and 16-bit timing
        for (int i = 0; i < 5; i++) begin
            hi = i[0];
            p = (i == 0) ? 8'd2 : 8'(2 + $urandom % 3);
            m = (i == 0) ? 8'hff : 8'(6 + $urandom % 4);
            m2 = 8'(6 + $urandom % 4);
            ctl = (i == 4) ? 8'he5 : hi ? 8'h84 : 8'h41;
            bus(`DBTC_IDX_CONTROL, 1'b1, 8'h00);
            bus(`DBTC_IDX_PRESCALE, 1'b1, p);
            bus(`DBTC_IDX_MATCH_LOW, 1'b1, m);
            bus(`DBTC_IDX_MATCH_HIGH, 1'b1, (i == 4) ? 8'h01 : m);
            rdchk("match data", hi ? `DBTC_IDX_MATCH_HIGH : `DBTC_IDX_MATCH_LOW, m);
            bus(`DBTC_IDX_CONTROL, 1'b1, ctl);
            waitIrq(hi, t0);
            bus(`DBTC_IDX_CONTROL, 1'b1, ctl);
            bus(hi ? `DBTC_IDX_MATCH_HIGH : `DBTC_IDX_MATCH_LOW, 1'b1, m2);
            if (i == 3) begin
                holdMode <= 1'b1;
                repeat (5) @(posedge core_clk);
                holdMode <= 1'b0;
            end
            waitIrq(hi, t1);
            // Hold cycles stretch the period one for one
            want = period((i == 4 ? 256 : 0) + m, p) + (i == 3 ? 5 : 0);
            check("period", t1 - t0, want);
            bus(`DBTC_IDX_CONTROL, 1'b1, ctl);
            waitIrq(hi, t2);
            check("reload period", t2 - t1, period((i == 4 ? 256 : 0) + m2, p));
        end
        $display("test timing done");
        // Event counting and capture routing in 8-bit mode
        bus(`DBTC_IDX_CONTROL, 1'b1, 8'h00);
        bus(`DBTC_IDX_MATCH_LOW, 1'b1, 8'h05);
        bus(`DBTC_IDX_CONTROL, 1'b1, 8'h51);
        repeat (3) u_evt.pulse(EV_CNT, $urandom % 3);
        rdchk("event count", `DBTC_IDX_COUNT_LOW, 8'h03);
        u_evt.pulse(EV_LC, 1);
        u_evt.pulse(EV_CNT, 1);
        u_evt.pulse(EV_HC, 1);
        u_evt.pulse(EV_LC2, 1);
        u_evt.pulse(EV_HC2, 1);
        rdchk("snap a low", `DBTC_IDX_SNAP_A_LOW, 8'h03);
        rdchk("snap a high", `DBTC_IDX_SNAP_A_HIGH, 8'h00);
        rdchk("snap b low", `DBTC_IDX_SNAP_B_LOW, 8'h04);
        u_evt.pulse(EV_CNT, 2);
        check("no early match", 32'(lowIrq), 32'h0);
        u_evt.pulse(EV_CNT, 2);
        check("event match", 32'(lowIrq), 32'h1);
        $display("test event mode done");
        // Cascaded 16-bit counter with coherent snapshots
        bus(`DBTC_IDX_CONTROL, 1'b1, 8'h00);
        bus(`DBTC_IDX_MATCH_LOW, 1'b1, 8'h02);
        bus(`DBTC_IDX_MATCH_HIGH, 1'b1, 8'h01);
        bus(`DBTC_IDX_CONTROL, 1'b1, 8'hf5);
        repeat (5) u_evt.pulse(EV_CNT, 0);
        u_evt.pulse(EV_HC, 0);
        u_evt.pulse(EV_CNT, 0);
        u_evt.pulse(EV_LC, 0);
        u_evt.pulse(EV_HC2, 0);
        rdchk("pair a low", `DBTC_IDX_SNAP_A_LOW, 8'h05);
        rdchk("pair b low", `DBTC_IDX_SNAP_B_LOW, 8'h06);
        rdchk("pair b high", `DBTC_IDX_SNAP_B_HIGH, 8'h00);
        repeat (251) u_evt.pulse(EV_CNT, 0);
        u_evt.pulse(EV_HC, 2);
        rdchk("carry a high", `DBTC_IDX_SNAP_A_HIGH, 8'h01);
        rdchk("carry a low", `DBTC_IDX_SNAP_A_LOW, 8'h01);
        check("no 16-bit match", 32'({highIrq, lowIrq}), 32'h0);
        // Match fires on the step away from 0x0102, so two more events
        repeat (2) u_evt.pulse(EV_CNT, 2);
        check("both flags", 32'({highIrq, lowIrq}), 32'h3);
        rdchk("cleared high", `DBTC_IDX_COUNT_HIGH, 8'h00);
        $display("test 16-bit done");
        test_done();
    end
endmodule
`default_nettype wire
